// ==== pcr_map.vh ====
// Constants for the configuration register space: offsets, fields, resets.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PCR_MAP_VH
`define PCR_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PCR_OFF_IDENT 8'h00
`define PCR_OFF_CMDSTAT 8'h04
`define PCR_OFF_REVISION 8'h08
`define PCR_OFF_LATENCY 8'h0c
`define PCR_OFF_IO_BASE 8'h10
`define PCR_OFF_MEM_BASE 8'h14
`define PCR_OFF_SUBSYS 8'h2c
`define PCR_OFF_ROM_BASE 8'h30
`define PCR_OFF_CAP_PTR 8'h34
`define PCR_OFF_INT_SEL 8'h3c
`define PCR_OFF_PM_CAP 8'h40
`define PCR_OFF_PM_CSR 8'h44

// ****************************************
// Command/status field positions
// ****************************************
`define PCR_BIT_PAR_DET 31
`define PCR_BIT_SYS_ERR 30
`define PCR_BIT_MST_ABT 29
`define PCR_BIT_TGT_ABT_RX 28
`define PCR_BIT_TGT_ABT_TX 27
`define PCR_BIT_SEL_TIM_HI 26
`define PCR_BIT_SEL_TIM_LO 25
`define PCR_BIT_DATA_PAR 24
`define PCR_BIT_FBB_CAP 23
`define PCR_BIT_NEW_CAP 20
`define PCR_BIT_FBB_EN 9
`define PCR_BIT_SERR_EN 8
`define PCR_BIT_PERR_RSP 6
`define PCR_BIT_BM_EN 2
`define PCR_BIT_MEM_EN 1
`define PCR_BIT_IO_EN 0
`define PCR_SEL_TIM_MEDIUM 2'b01

// ****************************************
// Reset values and write masks
// ****************************************
`define PCR_RST_CMDSTAT 32'h02900000
`define PCR_RST_ZERO 32'h00000000
`define PCR_MASK_CMD 16'h0347
`define PCR_MASK_FULL 32'hffffffff

`endif

// ==== pcr_wreg.v ====
// One host-writable 32-bit configuration register with byte enables.
// Assumes write strobe, enables and data arrive on clk_in from the target logic.
`timescale 1ns/1ns
`default_nettype none

module pcr_wreg #(
    parameter [31:0] RESET_VAL = 32'h00000000,
    parameter [31:0] WR_MASK = 32'hffffffff
) (
    input wire clk_in,
    input wire srst_in,
    input wire ce_in,
    input wire we_in,
    input wire [3:0] be_in,
    input wire [31:0] wdata_in,
    output wire [31:0] q_out
);

    reg [31:0] val_q;

    assign q_out = val_q;

    // ****************************************
    // Per-byte update
    // ****************************************
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_byte
            always @(posedge clk_in) begin
                if (srst_in) begin
                    val_q[8*b+7:8*b] <= RESET_VAL[8*b+7:8*b];
                end else if (ce_in && we_in && be_in[b]) begin
                    val_q[8*b+7:8*b] <= (wdata_in[8*b+7:8*b] & WR_MASK[8*b+7:8*b]) |
                        (val_q[8*b+7:8*b] & ~WR_MASK[8*b+7:8*b]);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== pcr_cfg_space.v ====
// Configuration register space of the network controller, on the bus clock.
// Assumes configuration reads and writes come from target logic on clk_in,
// one request at a time, and status events are one-cycle pulses on clk_in.
`timescale 1ns/1ns
`default_nettype none

`include "pcr_map.vh"

module pcr_cfg_space #(
    parameter [15:0] DEVICE_CODE = 16'h0a5a, // Arbitrary value
    parameter [15:0] VENDOR_CODE = 16'h1e5e, // Arbitrary value
    parameter [31:0] REVISION_VAL = 32'h02000001,
    parameter [31:0] LATENCY_VAL = 32'h00000000,
    parameter [31:0] SUBSYS_VAL = 32'h00000000, // Arbitrary value
    parameter [31:0] CAP_PTR_VAL = 32'h00000040,
    parameter [31:0] PM_CAP_VAL = 32'h00000001
) (
    input wire clk_in,
    input wire srst_in,
    input wire ce_in,
    input wire cfg_rd_in,
    input wire cfg_wr_in,
    input wire [7:0] cfg_addr_in,
    input wire [3:0] cfg_be_in,
    input wire [31:0] cfg_wdata_in,
    input wire par_det_in,
    input wire sys_err_in,
    input wire mst_abt_in,
    input wire tgt_abt_rx_in,
    input wire tgt_abt_tx_in,
    input wire data_par_in,
    input wire ncap_load_in,
    input wire ncap_value_in,
    output reg [31:0] cfg_rdata_out,
    output reg cfg_ack_out,
    output reg io_en_out,
    output reg mem_en_out,
    output reg bm_en_out,
    output reg perr_rsp_out,
    output reg serr_en_out,
    output reg fbb_en_out,
    output reg new_cap_en_out,
    output wire [31:0] io_base_out,
    output wire [31:0] mem_base_out,
    output wire [31:0] rom_base_out,
    output wire [31:0] int_sel_out,
    output wire [31:0] pm_csr_out
);

    // ****************************************
    // Address decode
    // ****************************************
    // Compare on the dword part only; byte lanes come from the enables
    function pcr_hit;
        input [7:0] addr;
        input [7:0] offs;
        begin
            pcr_hit = (addr[7:2] == offs[7:2]);
        end
    endfunction

    localparam NUM_WREG = 5;

    wire sel_cmdstat;
    wire [NUM_WREG-1:0] sel_wreg;
    wire [NUM_WREG-1:0] wreg_we;
    wire [32*NUM_WREG-1:0] wreg_q;
    wire cap_on;

    assign sel_cmdstat = pcr_hit(cfg_addr_in, `PCR_OFF_CMDSTAT);
    assign sel_wreg[0] = pcr_hit(cfg_addr_in, `PCR_OFF_IO_BASE);
    assign sel_wreg[1] = pcr_hit(cfg_addr_in, `PCR_OFF_MEM_BASE);
    assign sel_wreg[2] = pcr_hit(cfg_addr_in, `PCR_OFF_ROM_BASE);
    assign sel_wreg[3] = pcr_hit(cfg_addr_in, `PCR_OFF_INT_SEL);
    assign sel_wreg[4] = pcr_hit(cfg_addr_in, `PCR_OFF_PM_CSR);

    // ****************************************
    // Command/status storage
    // ****************************************
    reg par_det_q;
    reg sys_err_q;
    reg mst_abt_q;
    reg tgt_abt_rx_q;
    reg tgt_abt_tx_q;
    reg data_par_q;
    reg [15:0] cmd_q;
    reg new_cap_q;
    localparam [31:0] RST_CS = `PCR_RST_CMDSTAT;
    localparam [15:0] CMD_MASK = `PCR_MASK_CMD;
    wire wr_cs;
    wire clr_hi;
    wire [31:0] cs_word;

    assign wr_cs = cfg_wr_in && sel_cmdstat;
    assign cap_on = new_cap_q;

    // Status clear only where the top byte lane is enabled
    assign clr_hi = wr_cs && cfg_be_in[3];

    // Only srst_in resets this state; no soft reset input exists
    always @(posedge clk_in) begin
        if (srst_in) begin
            par_det_q <= RST_CS[`PCR_BIT_PAR_DET];
            sys_err_q <= RST_CS[`PCR_BIT_SYS_ERR];
            mst_abt_q <= RST_CS[`PCR_BIT_MST_ABT];
            tgt_abt_rx_q <= RST_CS[`PCR_BIT_TGT_ABT_RX];
            tgt_abt_tx_q <= RST_CS[`PCR_BIT_TGT_ABT_TX];
            data_par_q <= RST_CS[`PCR_BIT_DATA_PAR];
            cmd_q <= RST_CS[15:0];
            new_cap_q <= RST_CS[`PCR_BIT_NEW_CAP];
        end else if (ce_in) begin
            // Event in the clearing cycle still sets the flag
            par_det_q <= par_det_in |
                (par_det_q & ~(clr_hi & cfg_wdata_in[`PCR_BIT_PAR_DET]));
            sys_err_q <= sys_err_in |
                (sys_err_q & ~(clr_hi & cfg_wdata_in[`PCR_BIT_SYS_ERR]));
            mst_abt_q <= mst_abt_in |
                (mst_abt_q & ~(clr_hi & cfg_wdata_in[`PCR_BIT_MST_ABT]));
            tgt_abt_rx_q <= tgt_abt_rx_in |
                (tgt_abt_rx_q & ~(clr_hi & cfg_wdata_in[`PCR_BIT_TGT_ABT_RX]));
            tgt_abt_tx_q <= tgt_abt_tx_in |
                (tgt_abt_tx_q & ~(clr_hi & cfg_wdata_in[`PCR_BIT_TGT_ABT_TX]));
            data_par_q <= data_par_in |
                (data_par_q & ~(clr_hi & cfg_wdata_in[`PCR_BIT_DATA_PAR]));
            // Lower half: command fields, per byte lane
            if (wr_cs && cfg_be_in[0]) begin
                cmd_q[7:0] <= cfg_wdata_in[7:0] & CMD_MASK[7:0];
            end
            if (wr_cs && cfg_be_in[1]) begin
                cmd_q[15:8] <= cfg_wdata_in[15:8] & CMD_MASK[15:8];
            end
            // Capability enable comes from the configuration loader
            if (ncap_load_in) begin
                new_cap_q <= ncap_value_in;
            end
        end
    end

    // Fixed fields: select timing, fast back-to-back capable
    assign cs_word = {par_det_q, sys_err_q, mst_abt_q, tgt_abt_rx_q, tgt_abt_tx_q,
        `PCR_SEL_TIM_MEDIUM, data_par_q, 1'b1, 2'b00, new_cap_q, 4'h0,
        cmd_q};

    // ****************************************
    // Host-writable registers
    // ****************************************
    // Power control/status is frozen while capabilities are disabled
    assign wreg_we[3:0] = {4{cfg_wr_in}} & sel_wreg[3:0];
    assign wreg_we[4] = cfg_wr_in && sel_wreg[4] && cap_on;

    genvar r;
    generate
        for (r = 0; r < NUM_WREG; r = r + 1) begin : g_wreg
            pcr_wreg #(
                .RESET_VAL(`PCR_RST_ZERO),
                .WR_MASK(`PCR_MASK_FULL)
            ) u_wreg (
                .clk_in(clk_in),
                .srst_in(srst_in),
                .ce_in(ce_in),
                .we_in(wreg_we[r]),
                .be_in(cfg_be_in),
                .wdata_in(cfg_wdata_in),
                .q_out(wreg_q[32*r+31:32*r])
            );
        end
    endgenerate

    assign io_base_out = wreg_q[31:0];
    assign mem_base_out = wreg_q[63:32];
    assign rom_base_out = wreg_q[95:64];
    assign int_sel_out = wreg_q[127:96];
    assign pm_csr_out = wreg_q[159:128];

    // ****************************************
    // Read multiplexer
    // ****************************************
    reg [31:0] rd_mux;

    // Reserved and unmapped dwords fall to the default and read zero
    always @* begin
        rd_mux = 32'h00000000;
        case ({2'b00, cfg_addr_in[7:2]})
            `PCR_OFF_IDENT >> 2: begin
                rd_mux = {DEVICE_CODE, VENDOR_CODE};
            end
            `PCR_OFF_CMDSTAT >> 2: begin
                rd_mux = cs_word;
            end
            `PCR_OFF_REVISION >> 2: begin
                rd_mux = REVISION_VAL;
            end
            `PCR_OFF_LATENCY >> 2: begin
                rd_mux = LATENCY_VAL;
            end
            `PCR_OFF_IO_BASE >> 2: begin
                rd_mux = wreg_q[31:0];
            end
            `PCR_OFF_MEM_BASE >> 2: begin
                rd_mux = wreg_q[63:32];
            end
            `PCR_OFF_SUBSYS >> 2: begin
                rd_mux = SUBSYS_VAL;
            end
            `PCR_OFF_ROM_BASE >> 2: begin
                rd_mux = wreg_q[95:64];
            end
            `PCR_OFF_CAP_PTR >> 2: begin
                rd_mux = cap_on ? CAP_PTR_VAL : 32'h00000000;
            end
            `PCR_OFF_INT_SEL >> 2: begin
                rd_mux = wreg_q[127:96];
            end
            `PCR_OFF_PM_CAP >> 2: begin
                rd_mux = cap_on ? PM_CAP_VAL : 32'h00000000;
            end
            `PCR_OFF_PM_CSR >> 2: begin
                rd_mux = cap_on ? wreg_q[159:128] : 32'h00000000;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // ****************************************
    // Access answer
    // ****************************************
    // Every read or write taken with ce_in high is acknowledged one cycle later; writes read zero
    always @(posedge clk_in) begin
        if (srst_in) begin
            cfg_rdata_out <= 32'h00000000;
            cfg_ack_out <= 1'b0;
        end else if (ce_in) begin
            cfg_ack_out <= cfg_rd_in | cfg_wr_in;
            if (cfg_rd_in) begin
                cfg_rdata_out <= rd_mux;
            end else begin
                cfg_rdata_out <= 32'h00000000;
            end
        end
    end

    // ****************************************
    // Command outputs
    // ****************************************
    always @(posedge clk_in) begin
        if (srst_in) begin
            io_en_out <= 1'b0;
            mem_en_out <= 1'b0;
            bm_en_out <= 1'b0;
            perr_rsp_out <= 1'b0;
            serr_en_out <= 1'b0;
            fbb_en_out <= 1'b0;
            new_cap_en_out <= 1'b0;
        end else if (ce_in) begin
            io_en_out <= cmd_q[`PCR_BIT_IO_EN];
            mem_en_out <= cmd_q[`PCR_BIT_MEM_EN];
            bm_en_out <= cmd_q[`PCR_BIT_BM_EN];
            perr_rsp_out <= cmd_q[`PCR_BIT_PERR_RSP];
            serr_en_out <= cmd_q[`PCR_BIT_SERR_EN];
            fbb_en_out <= cmd_q[`PCR_BIT_FBB_EN];
            new_cap_en_out <= new_cap_q;
        end
    end

endmodule

`default_nettype wire

// ==== pcr_cfg_space_checker.sv ====
// Assertions on the configuration register space ports.
// Assumes a bind into pcr_cfg_space.
`timescale 1ns/1ns
`default_nettype none
module pcr_cfg_space_checker #(
    parameter [15:0] DEVICE_CODE = 16'h0000,
    parameter [15:0] VENDOR_CODE = 16'h0000
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic cfg_rd_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic mst_abt_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_ack_out,
    input wire logic io_en_out,
    input wire logic [31:0] io_base_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    wire [5:0] dw = cfg_addr_in[7:2];
    wire rd = ce_in && cfg_rd_in;
    wire wr = ce_in && cfg_wr_in;
    wire resv = (dw >= 6'h06 && dw <= 6'h0a) || dw == 6'h0e || dw >= 6'h12;
    sequence s_abort; ce_in && mst_abt_in; endsequence
    sequence s_rd_cs; rd && dw == 6'h01; endsequence
    property p_ack; rd || wr |=> cfg_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_ack_src; cfg_ack_out |-> $past(rd || wr); endproperty
    a_ack_src: assert property (p_ack_src) else $error("ack without request");
    property p_ident; rd && dw == 6'h00 |=> cfg_rdata_out == {DEVICE_CODE, VENDOR_CODE}; endproperty
    a_ident: assert property (p_ident) else $error("identity read wrong");
    property p_resv; rd && resv |=> cfg_rdata_out == 32'h00000000; endproperty
    a_resv: assert property (p_resv) else $error("reserved read not zero");
    property p_sel; s_rd_cs |=> cfg_rdata_out[26:25] == 2'b01 && cfg_rdata_out[15:10] == 6'h00;
    endproperty
    a_sel: assert property (p_sel) else $error("select timing wrong");
    property p_event; s_abort ##1 !wr ##1 s_rd_cs |=> cfg_rdata_out[29]; endproperty
    a_event: assert property (p_event) else $error("abort flag not set");
    property p_rst; $past(srst_in) |-> io_base_out == 32'h00000000; endproperty
    a_rst: assert property (p_rst) else $error("base not cleared by reset");
    property p_base; wr && dw == 6'h04 && cfg_be_in == 4'hf |=> io_base_out == $past(cfg_wdata_in);
    endproperty
    a_base: assert property (p_base) else $error("io base not written");
    property p_cmd; wr && dw == 6'h01 && cfg_be_in[0] ##1 ce_in |=> io_en_out == $past(cfg_wdata_in[0], 2);
    endproperty
    a_cmd: assert property (p_cmd) else $error("io enable wrong");
endmodule
`default_nettype wire

// ==== pcr_host_model.sv ====
// Host bridge model issuing single configuration accesses.
// Assumes the one-cycle request pulse and next-cycle ack of the target.
`timescale 1ns/1ns
`default_nettype none
module pcr_host_model (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [31:0] rdata_in,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] addr_out,
    output logic [3:0] be_out,
    output logic [31:0] wdata_out
);
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 8'h00;
        be_out = 4'h0;
        wdata_out = 32'h00000000;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
        output logic [31:0] q, output logic k);
        @(posedge clk_in);
        rd_out <= !w;
        wr_out <= w;
        addr_out <= a;
        be_out <= b;
        wdata_out <= d;
        @(posedge clk_in);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        addr_out <= ~a;
        be_out <= 4'h0;
        wdata_out <= ~d;
        @(posedge clk_in);
        q = rdata_in;
        k = ack_in;
    endtask
endmodule
`default_nettype wire

// ==== pcr_cfg_space_tb_top.sv ====
// Self-checking bench for the configuration register space.
// Assumes pcr_host_model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pcr_cfg_space_tb_top;
    localparam [15:0] DEV_CODE = 16'h3c3c; // Arbitrary value
    localparam [15:0] VEN_CODE = 16'h5a01; // Arbitrary value
    logic clk_in, srst_in, ce_in, ncap_load, ncap_value, k;
    logic [5:0] ev;
    logic [31:0] q;
    int checked = 0, miscompares = 0, cycles = 0;
    wire rd, wr, ack, io_en, mem_en, bm_en, perr, serr, fbb, ncap_en;
    wire [7:0] addr;
    wire [3:0] be;
    wire [31:0] wdata, rdata, io_b, mem_b, rom_b, int_s, pm_c;
    logic [7:0] ro_ofs [0:10] = '{8'h00, 8'h08, 8'h0c, 8'h2c, 8'h34, 8'h40,
        8'h18, 8'h28, 8'h38, 8'h48, 8'hfc};
    logic [7:0] rw_ofs [0:4] = '{8'h10, 8'h14, 8'h30, 8'h3c, 8'h44};
    logic [31:0] ro_exp [0:5] = '{{DEV_CODE, VEN_CODE}, 32'h00000011, 32'h00000022,
        32'h00000033, 32'h00000040, 32'h00000055};
    pcr_host_model host (.clk_in(clk_in), .ack_in(ack), .rdata_in(rdata), .rd_out(rd),
        .wr_out(wr), .addr_out(addr), .be_out(be), .wdata_out(wdata));
    pcr_cfg_space #(.DEVICE_CODE(DEV_CODE), .VENDOR_CODE(VEN_CODE),
        .REVISION_VAL(32'h00000011), .LATENCY_VAL(32'h00000022), .SUBSYS_VAL(32'h00000033),
        .CAP_PTR_VAL(32'h00000040), .PM_CAP_VAL(32'h00000055)) dut (.clk_in(clk_in),
        .srst_in(srst_in), .ce_in(ce_in), .cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_addr_in(addr),
        .cfg_be_in(be), .cfg_wdata_in(wdata), .par_det_in(ev[5]), .sys_err_in(ev[4]),
        .mst_abt_in(ev[3]), .tgt_abt_rx_in(ev[2]), .tgt_abt_tx_in(ev[1]), .data_par_in(ev[0]),
        .ncap_load_in(ncap_load), .ncap_value_in(ncap_value), .cfg_rdata_out(rdata),
        .cfg_ack_out(ack), .io_en_out(io_en), .mem_en_out(mem_en), .bm_en_out(bm_en),
        .perr_rsp_out(perr), .serr_en_out(serr), .fbb_en_out(fbb), .new_cap_en_out(ncap_en),
        .io_base_out(io_b), .mem_base_out(mem_b), .rom_base_out(rom_b), .int_sel_out(int_s),
        .pm_csr_out(pm_c));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            close_out;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        host.xfer(w, a, b, d, q, k);
        chk({31'h0, k}, 32'h1);
    endtask
    task rdx(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 4'hf, 32'h0);
        chk(q, e);
    endtask
    task t_reset;
        rdx(8'h04, 32'h02900000);
        rdx(8'h10, 32'h0);
        rdx(8'h00, {DEV_CODE, VEN_CODE});
        chk(io_b, 32'h0);
        chk({26'h0, fbb, serr, perr, bm_en, mem_en, io_en}, 32'h0);
        chk({31'h0, ncap_en}, 32'h1);
    endtask
    task t_ro;
        logic [31:0] v;
        for (int i = 0; i < 11; i++) begin
            acc(1'b0, ro_ofs[i], 4'hf, 32'h0);
            v = q;
            if (i > 5) chk(v, 32'h0);
            else chk(v, ro_exp[i]);
            acc(1'b1, ro_ofs[i], 4'hf, 32'hffffffff);
            rdx(ro_ofs[i], v);
        end
    endtask
    task t_rw;
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, rw_ofs[i], 4'hf, {24'ha5c396, rw_ofs[i]});
            acc(1'b1, rw_ofs[i], 4'h5, 32'h0);
            rdx(rw_ofs[i], 32'ha5009600);
        end
        chk(io_b, 32'ha5009600);
        chk(mem_b, 32'ha5009600);
        chk(rom_b, 32'ha5009600);
        chk(int_s, 32'ha5009600);
        chk(pm_c, 32'ha5009600);
    endtask
    task t_cmd;
        acc(1'b1, 8'h04, 4'h3, 32'hffffffff);
        rdx(8'h04, 32'h02900347);
        chk({26'h0, fbb, serr, perr, bm_en, mem_en, io_en}, 32'h3f);
        acc(1'b1, 8'h04, 4'hc, 32'h0);
        rdx(8'h04, 32'h02900347);
    endtask
    task t_stat;
        @(posedge clk_in) ev <= 6'h3f;
        @(posedge clk_in) ev <= 6'h00;
        rdx(8'h04, 32'hfb900347);
        acc(1'b1, 8'h04, 4'h8, 32'h28000000);
        rdx(8'h04, 32'hd3900347);
        acc(1'b1, 8'h04, 4'h7, 32'hffffffff);
        rdx(8'h04, 32'hd3900347);
        // Abort event in the same cycle as its clear: the set wins
        fork
            acc(1'b1, 8'h04, 4'h8, 32'h20000000);
            begin
                @(posedge clk_in) ev <= 6'h08;
                @(posedge clk_in) ev <= 6'h00;
            end
        join
        rdx(8'h04, 32'hf3900347);
    endtask
    task t_cap;
        @(posedge clk_in) {ncap_load, ncap_value} <= 2'b10;
        @(posedge clk_in) ncap_load <= 1'b0;
        rdx(8'h34, 32'h0);
        rdx(8'h40, 32'h0);
        rdx(8'h44, 32'h0);
        chk({31'h0, ncap_en}, 32'h0);
        acc(1'b1, 8'h44, 4'hf, 32'hffffffff);
        @(posedge clk_in) {ncap_load, ncap_value} <= 2'b11;
        @(posedge clk_in) ncap_load <= 1'b0;
        rdx(8'h44, 32'ha5009600);
        chk({31'h0, ncap_en}, 32'h1);
    endtask
    task t_ce;
        @(posedge clk_in) ce_in <= 1'b0;
        host.xfer(1'b1, 8'h10, 4'hf, 32'h0, q, k);
        chk({31'h0, k}, 32'h0);
        @(posedge clk_in) ce_in <= 1'b1;
        rdx(8'h10, 32'ha5009600);
    endtask
    initial begin
        srst_in = 1'b1;
        ce_in = 1'b1;
        ev = 6'h00;
        ncap_load = 1'b0;
        ncap_value = 1'b1;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset;
        t_ro;
        t_rw;
        t_cmd;
        t_stat;
        t_cap;
        t_ce;
        @(posedge clk_in) srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset;
        close_out;
    end
endmodule
bind pcr_cfg_space pcr_cfg_space_checker #(.DEVICE_CODE(DEVICE_CODE),
    .VENDOR_CODE(VENDOR_CODE)) u_chk (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .cfg_rd_in(cfg_rd_in), .cfg_wr_in(cfg_wr_in), .cfg_addr_in(cfg_addr_in),
    .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in), .mst_abt_in(mst_abt_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out), .io_en_out(io_en_out),
    .io_base_out(io_base_out));
`default_nettype wire
